// [hdl/cmu_consts.svh]
`ifndef CMU_CONSTS_SVH
`define CMU_CONSTS_SVH

// Register byte offsets
`define CMU_REG_INSTR_LO   8'h00
`define CMU_REG_INSTR_HI   8'h04
`define CMU_REG_PARCEL     8'h08
`define CMU_REG_BASE       8'h0c
`define CMU_REG_TBASE      8'h10
`define CMU_REG_FLC        8'h14
`define CMU_REG_CTRL       8'h18
`define CMU_REG_STATUS     8'h1c
`define CMU_REG_X0_LO      8'h20
`define CMU_REG_X0_HI      8'h24

`define CMU_RESP_OKAY      2'h0
`define CMU_RESP_SLVERR    2'h2

// Instruction and descriptor word layout
`define CMU_OP_HI          59
`define CMU_OP_LO          51
`define CMU_OPC_IND        9'h134
`define CMU_OPC_DIR        9'h135
`define CMU_OPC_CMP        9'h136
`define CMU_LUD_HI         50
`define CMU_LUD_LO         48
`define CMU_LUI_HI         59
`define CMU_LUI_LO         51
`define CMU_K1_HI          47
`define CMU_K1_LO          30
`define CMU_LL_HI          29
`define CMU_LL_LO          26
`define CMU_C1_HI          25
`define CMU_C1_LO          22
`define CMU_C2_HI          21
`define CMU_C2_LO          18
`define CMU_K2_HI          17
`define CMU_K2_LO          0
`define CMU_HI_W           28

// Character geometry and limits
`define CMU_CHAR_W         6
`define CMU_SLOT_MAX       4'h9
`define CMU_SLOTS          10
`define CMU_XJ_LIMIT       13'h0ff
`define CMU_CNT_W          9
`define CMU_COL_HI         5
`define CMU_COL_LO         3

// Control and status bits
`define CMU_CTRL_START     0
`define CMU_ST_BUSY        0
`define CMU_ST_DONE        1
`define CMU_ST_ILLEGAL     2
`define CMU_ST_OOR         3
`define CMU_ST_PASS        4
`define CMU_ST_INTR        5
`define CMU_ST_SKIP        6

`endif

// [hdl/cmu_pkg.sv]
package cmu_pkg;

	// Gray codes in declaration order
	typedef enum logic [3:0] {
		CMU_S_IDLE   = 4'h0,
		CMU_S_DECODE = 4'h1,
		CMU_S_DESC   = 4'h3,
		CMU_S_CHECK  = 4'h2,
		CMU_S_STEP   = 4'h6,
		CMU_S_RSRC   = 4'h7,
		CMU_S_RDST   = 4'h5,
		CMU_S_COLA   = 4'h4,
		CMU_S_COLB   = 4'hc,
		CMU_S_WDST   = 4'hd,
		CMU_S_DONE   = 4'hf
	} cmu_state_t;

	typedef struct packed {
		cmu_state_t  state;
		logic [59:0] instr;
		logic [1:0]  parcel;
		logic [17:0] base;
		logic [17:0] tbase;
		logic [17:0] program_field_length;
		logic [59:0] x0;
		logic        is_cmp;
		logic        is_ind;
		logic [12:0] len;
		logic [12:0] rem;
		logic [17:0] k1;
		logic [17:0] k2;
		logic [3:0]  c1;
		logic [3:0]  c2;
		logic [59:0] src_buf;
		logic [59:0] dst_buf;
		logic        src_ok;
		logic        dst_ok;
		logic        dirty;
		logic        coll_eq;
		logic        stop;
		logic [5:0]  ch_a;
		logic [5:0]  ch_b;
		logic [5:0]  col_a;
		logic [6:0]  status;
		logic        mem_req;
		logic        mem_we;
		logic [17:0] mem_addr;
		logic [59:0] mem_wdata;
		logic        aw_got;
		logic        w_got;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} cmu_regs_t;

endpackage

// [hdl/cmu_char_move_unit.sv]
`timescale 1ns/1ps
`include "cmu_consts.svh"
`default_nettype none

module cmu_char_move_unit
	import cmu_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        exch_jump_req,
	output logic             mem_req,
	output logic             mem_we,
	output logic [17:0]      mem_addr,
	output logic [59:0]      mem_wdata,
	input  wire logic        mem_ack,
	input  wire logic [59:0] mem_rdata
);

	cmu_regs_t r_reg;
	cmu_regs_t r_next;

	function automatic logic [5:0] getc(input logic [59:0] w,
		input logic [3:0] s);
		getc = w[`CMU_CHAR_W * (`CMU_SLOT_MAX - s) +: `CMU_CHAR_W];
	endfunction

	function automatic logic [59:0] putc(input logic [59:0] w,
		input logic [3:0] s, input logic [5:0] c);
		logic [59:0] o;
		o = w;
		o[`CMU_CHAR_W * (`CMU_SLOT_MAX - s) +: `CMU_CHAR_W] = c;
		putc = o;
	endfunction

	// Memory words touched by a field starting at slot c
	function automatic logic [18:0] refs(input logic [3:0] c,
		input logic [12:0] l);
		logic [18:0] t;
		t = 19'({15'h0000, c}) + 19'(l) + 19'(`CMU_SLOT_MAX);
		refs = 19'(t / 19'(`CMU_SLOTS));
	endfunction

	function automatic logic [31:0] wmerge(input logic [31:0] old,
		input logic [31:0] d, input logic [3:0] st);
		logic [31:0] o;
		o = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i])
				o[i*8 +: 8] = d[i*8 +: 8];
		end
		wmerge = o;
	endfunction

	function automatic logic reg_ok(input logic [7:0] a);
		reg_ok = (a[1:0] == 2'h0) && (a <= `CMU_REG_X0_HI);
	endfunction

	function automatic logic [31:0] rd_mux(input cmu_regs_t s,
		input logic [7:0] a);
		case (a)
			`CMU_REG_INSTR_LO: rd_mux = s.instr[31:0];
			`CMU_REG_INSTR_HI: rd_mux = {4'h0, s.instr[59:32]};
			`CMU_REG_PARCEL:   rd_mux = {30'h0, s.parcel};
			`CMU_REG_BASE:     rd_mux = {14'h0, s.base};
			`CMU_REG_TBASE:    rd_mux = {14'h0, s.tbase};
			`CMU_REG_FLC:      rd_mux = {14'h0, s.program_field_length};
			`CMU_REG_STATUS:   rd_mux = {25'h0, s.status};
			`CMU_REG_X0_LO:    rd_mux = s.x0[31:0];
			`CMU_REG_X0_HI:    rd_mux = {4'h0, s.x0[59:32]};
			default:           rd_mux = 32'h0;
		endcase
	endfunction

	// Field decode shared by direct and descriptor forms
	function automatic cmu_regs_t load_fields(input cmu_regs_t s,
		input logic [59:0] w, input logic [8:0] lu);
		cmu_regs_t o;
		o = s;
		o.len = {lu, w[`CMU_LL_HI:`CMU_LL_LO]};
		o.rem = o.len;
		o.k1 = w[`CMU_K1_HI:`CMU_K1_LO];
		o.c1 = w[`CMU_C1_HI:`CMU_C1_LO];
		o.c2 = w[`CMU_C2_HI:`CMU_C2_LO];
		o.k2 = w[`CMU_K2_HI:`CMU_K2_LO];
		load_fields = o;
	endfunction

	logic [8:0]  opc;
	logic [5:0]  cur_a;
	logic [5:0]  cur_b;
	logic [5:0]  col_b;
	logic [8:0]  cnt;
	logic        src_bad;
	logic        dst_bad;

	assign opc = r_reg.instr[`CMU_OP_HI:`CMU_OP_LO];
	assign cur_a = getc(r_reg.src_buf, r_reg.c1);
	assign cur_b = getc(r_reg.dst_buf, r_reg.c2);
	assign col_b = getc(mem_rdata, {1'b0, r_reg.ch_b[2:0]});
	assign cnt = r_reg.rem[`CMU_CNT_W-1:0];
	assign src_bad = ({1'b0, r_reg.k1} + refs(r_reg.c1, r_reg.len))
		> {1'b0, r_reg.program_field_length};
	assign dst_bad = ({1'b0, r_reg.k2} + refs(r_reg.c2, r_reg.len))
		> {1'b0, r_reg.program_field_length};

	assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
	assign s_axi_wready = !r_reg.w_got && !r_reg.bvalid;
	assign s_axi_arready = !r_reg.rvalid;
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp = r_reg.bresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata = r_reg.rdata;
	assign s_axi_rresp = r_reg.rresp;
	assign mem_req = r_reg.mem_req;
	assign mem_we = r_reg.mem_we;
	assign mem_addr = r_reg.mem_addr;
	assign mem_wdata = r_reg.mem_wdata;

	always_comb begin
		logic busy;
		logic [31:0] cur;
		busy = r_reg.status[`CMU_ST_BUSY];
		cur = 32'h0;
		r_next = r_reg;

		// Register write channel; both halves may arrive in either order
		if (s_axi_awvalid && s_axi_awready) begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata;
			r_next.wstrb = s_axi_wstrb;
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;
		if (r_reg.aw_got && r_reg.w_got) begin
			r_next.aw_got = 1'b0;
			r_next.w_got = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp = reg_ok(r_reg.awaddr) ? `CMU_RESP_OKAY
				: `CMU_RESP_SLVERR;
			cur = wmerge(rd_mux(r_reg, r_reg.awaddr), r_reg.wdata,
				r_reg.wstrb);
			// Setup is frozen while an instruction runs
			if (!busy) begin
				case (r_reg.awaddr)
					`CMU_REG_INSTR_LO: r_next.instr[31:0] = cur;
					`CMU_REG_INSTR_HI: r_next.instr[59:32] = cur[`CMU_HI_W-1:0];
					`CMU_REG_PARCEL:   r_next.parcel = cur[1:0];
					`CMU_REG_BASE:     r_next.base = cur[17:0];
					`CMU_REG_TBASE:    r_next.tbase = cur[17:0];
					`CMU_REG_FLC:      r_next.program_field_length = cur[17:0];
					`CMU_REG_CTRL: begin
						if (r_reg.wstrb[0] && r_reg.wdata[`CMU_CTRL_START]) begin
							r_next.status = 7'h0;
							r_next.status[`CMU_ST_BUSY] = 1'b1;
							r_next.state = CMU_S_DECODE;
						end
					end
					default: ;
				endcase
			end
		end

		// Register read channel
		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && !r_reg.rvalid) begin
			r_next.rvalid = 1'b1;
			r_next.rdata = rd_mux(r_reg, s_axi_araddr);
			r_next.rresp = reg_ok(s_axi_araddr) ? `CMU_RESP_OKAY
				: `CMU_RESP_SLVERR;
		end

		unique case (r_reg.state)
			CMU_S_IDLE: ;
			CMU_S_DECODE: begin
				r_next.is_cmp = (opc == `CMU_OPC_CMP);
				r_next.is_ind = (opc == `CMU_OPC_IND);
				r_next.src_ok = 1'b0;
				r_next.dst_ok = 1'b0;
				r_next.dirty = 1'b0;
				r_next.coll_eq = 1'b0;
				r_next.stop = 1'b0;
				if (r_reg.parcel != 2'h0 || (opc != `CMU_OPC_IND
					&& opc != `CMU_OPC_DIR && opc != `CMU_OPC_CMP)) begin
					r_next.status[`CMU_ST_ILLEGAL] = 1'b1;
					r_next.state = CMU_S_DONE;
				end else if (opc == `CMU_OPC_IND) begin
					r_next.status[`CMU_ST_SKIP] = 1'b1;
					r_next.state = CMU_S_DESC;
				end else begin
					r_next = load_fields(r_next, r_reg.instr,
						{6'h00, r_reg.instr[`CMU_LUD_HI:`CMU_LUD_LO]});
					r_next.state = CMU_S_CHECK;
				end
			end
			CMU_S_DESC: begin
				if (mem_ack) begin
					r_next = load_fields(r_next, mem_rdata,
						mem_rdata[`CMU_LUI_HI:`CMU_LUI_LO]);
					r_next.state = CMU_S_CHECK;
				end
			end
			CMU_S_CHECK: begin
				if (r_reg.len == 13'h0000) begin
					r_next.status[`CMU_ST_PASS] = 1'b1;
					r_next.state = CMU_S_DONE;
				end else if (r_reg.c1 > `CMU_SLOT_MAX
					|| r_reg.c2 > `CMU_SLOT_MAX || src_bad || dst_bad) begin
					r_next.status[`CMU_ST_OOR] = 1'b1;
					r_next.state = CMU_S_DONE;
				end else begin
					r_next.state = CMU_S_STEP;
				end
			end
			CMU_S_RSRC: begin
				if (mem_ack) begin
					r_next.src_buf = mem_rdata;
					r_next.src_ok = 1'b1;
					r_next.state = CMU_S_STEP;
				end
			end
			CMU_S_RDST: begin
				if (mem_ack) begin
					r_next.dst_buf = mem_rdata;
					r_next.dst_ok = 1'b1;
					r_next.state = CMU_S_STEP;
				end
			end
			CMU_S_STEP: begin
				if (exch_jump_req && r_reg.rem > `CMU_XJ_LIMIT) begin
					r_next.status[`CMU_ST_INTR] = 1'b1;
					r_next.stop = 1'b1;
					r_next.state = r_reg.dirty ? CMU_S_WDST : CMU_S_DONE;
				end else if (!r_reg.src_ok) begin
					r_next.state = CMU_S_RSRC;
				end else if (!r_reg.dst_ok) begin
					// Move reads the result word too, to keep its other slots
					r_next.state = CMU_S_RDST;
				end else if (r_reg.is_cmp && cur_a != cur_b
					&& !r_reg.coll_eq) begin
					r_next.ch_a = cur_a;
					r_next.ch_b = cur_b;
					r_next.state = CMU_S_COLA;
				end else begin
					r_next.coll_eq = 1'b0;
					if (!r_reg.is_cmp) begin
						r_next.dst_buf = putc(r_reg.dst_buf, r_reg.c2, cur_a);
						r_next.dirty = 1'b1;
					end
					r_next.rem = r_reg.rem - 13'h0001;
					if (r_reg.c1 == `CMU_SLOT_MAX) begin
						r_next.c1 = 4'h0;
						r_next.k1 = r_reg.k1 + 18'h00001;
						r_next.src_ok = 1'b0;
					end else begin
						r_next.c1 = r_reg.c1 + 4'h1;
					end
					if (r_reg.is_cmp) begin
						if (r_reg.c2 == `CMU_SLOT_MAX) begin
							r_next.c2 = 4'h0;
							r_next.k2 = r_reg.k2 + 18'h00001;
							r_next.dst_ok = 1'b0;
						end else begin
							r_next.c2 = r_reg.c2 + 4'h1;
						end
						if (r_reg.rem == 13'h0001) begin
							r_next.x0 = 60'h0;
							r_next.state = CMU_S_DONE;
						end
					end else if (r_reg.c2 == `CMU_SLOT_MAX
						|| r_reg.rem == 13'h0001) begin
						r_next.state = CMU_S_WDST;
					end else begin
						r_next.c2 = r_reg.c2 + 4'h1;
					end
				end
			end
			CMU_S_COLA: begin
				if (mem_ack) begin
					r_next.col_a = getc(mem_rdata,
						{1'b0, r_reg.ch_a[2:0]});
					r_next.state = CMU_S_COLB;
				end
			end
			CMU_S_COLB: begin
				if (mem_ack) begin
					if (col_b == r_reg.col_a) begin
						r_next.coll_eq = 1'b1;
						r_next.state = CMU_S_STEP;
					end else begin
						if (r_reg.col_a < col_b)
							r_next.x0 = {{51{1'b1}}, ~cnt};
						else
							r_next.x0 = {51'h0, cnt};
						r_next.state = CMU_S_DONE;
					end
				end
			end
			CMU_S_WDST: begin
				if (mem_ack) begin
					r_next.dirty = 1'b0;
					r_next.dst_ok = 1'b0;
					if (r_reg.c2 == `CMU_SLOT_MAX) begin
						r_next.c2 = 4'h0;
						r_next.k2 = r_reg.k2 + 18'h00001;
					end else begin
						r_next.c2 = r_reg.c2 + 4'h1;
					end
					r_next.state = (r_reg.rem == 13'h0000 || r_reg.stop)
						? CMU_S_DONE : CMU_S_STEP;
				end
			end
			CMU_S_DONE: begin
				// Descriptor move leaves the result register clear
				if (r_reg.is_ind && !r_reg.status[`CMU_ST_ILLEGAL]
					&& !r_reg.status[`CMU_ST_OOR]
					&& !r_reg.status[`CMU_ST_PASS])
					r_next.x0 = 60'h0;
				r_next.status[`CMU_ST_BUSY] = 1'b0;
				r_next.status[`CMU_ST_DONE] = 1'b1;
				r_next.state = CMU_S_IDLE;
			end
			default: r_next.state = CMU_S_IDLE;
		endcase

		// Memory request follows the state about to be entered
		r_next.mem_req = 1'b1;
		r_next.mem_we = 1'b0;
		r_next.mem_wdata = r_reg.mem_wdata;
		case (r_next.state)
			CMU_S_DESC: r_next.mem_addr = r_reg.base
				+ r_reg.instr[`CMU_K1_HI:`CMU_K1_LO];
			CMU_S_RSRC: r_next.mem_addr = r_next.k1;
			CMU_S_RDST: r_next.mem_addr = r_next.k2;
			CMU_S_COLA: r_next.mem_addr = r_reg.tbase
				+ {15'h0, r_next.ch_a[`CMU_COL_HI:`CMU_COL_LO]};
			CMU_S_COLB: r_next.mem_addr = r_reg.tbase
				+ {15'h0, r_next.ch_b[`CMU_COL_HI:`CMU_COL_LO]};
			CMU_S_WDST: begin
				r_next.mem_we = 1'b1;
				r_next.mem_addr = r_next.k2;
				r_next.mem_wdata = r_next.dst_buf;
			end
			default: begin
				r_next.mem_req = 1'b0;
				r_next.mem_addr = r_reg.mem_addr;
			end
		endcase
		// A request never repeats in the cycle its ack arrives
		if (mem_ack && r_reg.state == r_next.state)
			r_next.mem_req = r_reg.mem_req;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

endmodule

`default_nettype wire

// [tb/cmu_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none

module cmu_mem_model (
	input  wire logic        clk,
	input  wire logic        slow,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [17:0] mem_addr,
	input  wire logic [59:0] mem_wdata,
	output var logic         mem_ack,
	output var logic [59:0]  mem_rdata,
	output var logic [15:0]  n_writes
);
	logic [59:0] mem [256];
	logic [1:0]  dly;

	initial begin
		mem_ack = 1'b0;
		mem_rdata = '0;
		n_writes = '0;
		dly = '0;
	end

	// Data lines invert the last word every cycle between answers
	always @(posedge clk) begin
		if (mem_req && !mem_ack && dly >= (slow ? 2'd3 : 2'd0)) begin
			mem_ack <= 1'b1;
			dly <= 2'd0;
			if (mem_we) begin
				mem[mem_addr[7:0]] <= mem_wdata;
				n_writes <= n_writes + 16'h1;
			end
			mem_rdata <= mem_we ? ~mem_rdata : mem[mem_addr[7:0]];
		end else begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			dly <= (mem_req && !mem_ack) ? dly + 2'd1 : 2'd0;
		end
	end
endmodule

`default_nettype wire

// [tb/cmu_char_move_unit_checker.sv]
`timescale 1ns/1ps
`include "cmu_consts.svh"
`default_nettype none

module cmu_char_move_unit_checker (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	input  wire logic        s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic        s_axi_wvalid,
	input  wire logic        s_axi_wready,
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [17:0] mem_addr
);
	logic [59:0] ins;
	logic [1:0]  par;
	logic [17:0] base;
	logic [17:0] tbase;
	logic        first;
	logic        hs;
	logic        dform;
	logic [8:0]  opc;
	logic [17:0] k1;
	logic [17:0] k2;

	assign hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	assign opc = ins[59:51];
	assign k1 = ins[47:30];
	assign k2 = ins[17:0];
	assign dform = opc == `CMU_OPC_DIR || opc == `CMU_OPC_CMP;

	// Shadow setup; valid since setup is only written while idle
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			ins <= '0;
			par <= '0;
			base <= '0;
			tbase <= '0;
			first <= 1'b0;
		end else begin
			if (hs) begin
				case (s_axi_awaddr)
				`CMU_REG_INSTR_LO: ins[31:0] <= s_axi_wdata;
				`CMU_REG_INSTR_HI: ins[59:32] <= s_axi_wdata[27:0];
				`CMU_REG_PARCEL:   par <= s_axi_wdata[1:0];
				`CMU_REG_BASE:     base <= s_axi_wdata[17:0];
				`CMU_REG_TBASE:    tbase <= s_axi_wdata[17:0];
				default:           ;
				endcase
			end
			if (mem_req)
				first <= 1'b0;
			else if (hs && s_axi_awaddr == `CMU_REG_CTRL && s_axi_wdata[0])
				first <= 1'b1;
		end
	end

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	a_illegal_no_req: assert property (
		par != 2'h0 || opc == 9'h137 |-> !mem_req)
		else $error("memory request for an illegal instruction");
	a_cmp_no_write: assert property (
		opc == `CMU_OPC_CMP |-> !(mem_req && mem_we))
		else $error("compare wrote memory");
	a_slot_no_exec: assert property (
		dform && (ins[25:22] > 4'h9 || ins[21:18] > 4'h9) |-> !mem_req)
		else $error("slot above nine executed");
	a_zero_len_pass: assert property (
		dform && {ins[50:48], ins[29:26]} == 7'h0 |-> !mem_req)
		else $error("zero length touched memory");
	a_desc_fetch_addr: assert property (
		first && mem_req && opc == `CMU_OPC_IND
		|-> !mem_we && mem_addr == base + k1)
		else $error("descriptor fetched from wrong word");
	a_src_read_first: assert property (
		first && mem_req && opc == `CMU_OPC_DIR |-> !mem_we && mem_addr == k1)
		else $error("move did not start at source word");
	a_dst_span: assert property (
		opc == `CMU_OPC_DIR && mem_req && mem_we |-> mem_addr - k2 < 18'd14)
		else $error("direct move wrote outside its span");
	a_cmp_table_word: assert property (
		opc == `CMU_OPC_CMP && mem_req |-> mem_addr - k1 < 18'd14
		|| mem_addr - k2 < 18'd14 || mem_addr - tbase < 18'd8)
		else $error("compare read outside fields and table");
endmodule

bind cmu_char_move_unit cmu_char_move_unit_checker u_chk (
	.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid),
	.s_axi_wready(s_axi_wready), .mem_req(mem_req), .mem_we(mem_we),
	.mem_addr(mem_addr)
);

`default_nettype wire

// [tb/cmu_char_move_unit_tb.sv]
`timescale 1ns/1ps
`include "cmu_consts.svh"
`default_nettype none

module cmu_char_move_unit_tb;
	typedef struct {
		logic [59:0] ins;
		logic [1:0]  par;
		logic [17:0] tbs;
		logic [6:0]  st;
		logic [59:0] x0;
	} cmu_row_t;
	localparam logic [8:0] op_cmp = `CMU_OPC_CMP;
	logic        clk = 1'b0, sys_rst = 1'b1;
	logic [7:0]  aw_a = 8'h0, ar_a = 8'h0;
	logic [31:0] w_d = 32'h0, rv, r_d;
	logic        aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
	logic        xj = 0, slow = 0;
	logic        aw_r, w_r, b_v, ar_r, r_v, m_req, m_we, m_ack;
	logic [1:0]  b_rs, r_rs, rs;
	logic [17:0] m_addr;
	logic [59:0] m_wd, m_rd, x0;
	logic [15:0] n_wr, wr0;
	logic [6:0]  st;
	logic [59:0] shadow [256];
	cmu_row_t    rows [10];
	int          n_mismatch = 0, samples_checked = 0, cycles = 0;

	cmu_char_move_unit u_dut (
		.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(aw_a),
		.s_axi_awvalid(aw_v), .s_axi_awready(aw_r), .s_axi_wdata(w_d),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(w_v), .s_axi_wready(w_r),
		.s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
		.s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r),
		.s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v),
		.s_axi_rready(r_r), .exch_jump_req(xj), .mem_req(m_req),
		.mem_we(m_we), .mem_addr(m_addr), .mem_wdata(m_wd),
		.mem_ack(m_ack), .mem_rdata(m_rd)
	);
	cmu_mem_model u_mem (
		.clk(clk), .slow(slow), .mem_req(m_req), .mem_we(m_we),
		.mem_addr(m_addr), .mem_wdata(m_wd), .mem_ack(m_ack),
		.mem_rdata(m_rd), .n_writes(n_wr)
	);

	always #12.5 clk = ~clk;
	// Whole run needs well under ten thousand cycles
	always @(posedge clk) begin
		cycles++;
		if (cycles == 50000) begin
			n_mismatch++;
			test_done();
		end
	end

	task automatic test_done();
		$display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Readies are settled at the falling edge, taken at the next rising one
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
			output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge clk);
		aw_a <= a;
		w_d <= d;
		aw_v <= 1'b1;
		w_v <= 1'b1;
		b_r <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge clk);
			ta = aw_v && aw_r;
			tw = w_v && w_r;
			tb = b_v;
			r = b_rs;
			@(posedge clk);
			if (ta) aw_v <= 1'b0;
			if (tw) w_v <= 1'b0;
			if (tb) b_r <= 1'b0;
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
			output logic [1:0] r);
		logic ta, tr;
		@(posedge clk);
		ar_a <= a;
		ar_v <= 1'b1;
		r_r <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge clk);
			ta = ar_v && ar_r;
			tr = r_v;
			d = r_d;
			r = r_rs;
			@(posedge clk);
			if (ta) ar_v <= 1'b0;
			if (tr) r_r <= 1'b0;
		end
	endtask

	task automatic load(input logic [59:0] ins);
		wr(`CMU_REG_INSTR_LO, ins[31:0], rs);
		wr(`CMU_REG_INSTR_HI, {4'h0, ins[59:32]}, rs);
	endtask

	task automatic run();
		wr(`CMU_REG_CTRL, 32'h1, rs);
		rv = 32'h1;
		while (rv[0] !== 1'b0)
			rd(`CMU_REG_STATUS, rv, rs);
		st = rv[6:0];
		rd(`CMU_REG_X0_LO, rv, rs);
		x0[31:0] = rv;
		rd(`CMU_REG_X0_HI, rv, rs);
		x0[59:32] = rv[27:0];
	endtask

	function automatic logic [59:0] cins(input logic [8:0] op,
			input logic [17:0] k1, input logic [3:0] c1,
			input logic [17:0] k2, input logic [3:0] c2, input logic [6:0] n);
		return {op, n[6:4], k1, n[3:0], c1, c2, k2};
	endfunction

	// Expected move, one character at a time, slot 0 most significant
	task automatic emove(input int k1, input int c1, input int k2,
			input int c2, input int n);
		for (int i = 0; i < n; i++)
			shadow[k2 + (c2 + i) / 10][59 - 6 * ((c2 + i) % 10) -: 6] =
				shadow[k1 + (c1 + i) / 10][59 - 6 * ((c1 + i) % 10) -: 6];
	endtask

	task automatic chk_mem();
		for (int i = 0; i < 256; i++)
			chk(u_mem.mem[i], shadow[i]);
	endtask

	initial begin
		foreach (shadow[i])
			shadow[i] = (i >= 100) ? 60'h555555555555555 : 60'h0;
		for (int i = 190; i < 200; i++)
			shadow[i] = 60'h0;
		for (int i = 16; i < 48; i++)
			for (int s = 0; s < 10; s++)
				shadow[i][59 - 6 * s -: 6] = 6'((i * 10 + s) % 64);
		shadow[32] = shadow[16];
		shadow[33] = shadow[17];
		shadow[33][35:30] = 6'h3f;
		for (int i = 0; i < 64; i++) begin
			shadow[64 + i / 8][59 - 6 * (i % 8) -: 6] = 6'(i);
			shadow[80 + i / 8][59 - 6 * (i % 8) -: 6] = 6'(i);
		end
		// Second table folds 0x3f onto 0x2e
		shadow[87][17:12] = 6'h2e;
		shadow[60] = {9'h012, 3'h0, 18'd16, 4'hc, 4'h1, 4'h2, 18'd110};
		foreach (shadow[i])
			u_mem.mem[i] = shadow[i];
		rows[0] = '{cins(op_cmp, 16, 0, 32, 0, 14), 0, 64, 0, 0};
		rows[1] = '{cins(op_cmp, 16, 0, 32, 0, 20), 0, 64, 0,
			{{51{1'b1}}, ~9'd6}};
		rows[2] = '{cins(op_cmp, 32, 0, 16, 0, 20), 0, 64, 0, {51'h0, 9'd6}};
		rows[3] = '{cins(op_cmp, 16, 0, 32, 0, 20), 0, 80, 0, 0};
		rows[4] = '{cins(op_cmp, 16, 0, 32, 0, 20), 1, 64, 7'h04, 0};
		rows[5] = '{cins(9'h137, 16, 0, 32, 0, 20), 0, 64, 7'h04, 0};
		rows[6] = '{cins(op_cmp, 16, 10, 32, 0, 20), 0, 64, 7'h08, 0};
		rows[7] = '{cins(op_cmp, 16, 0, 190, 0, 100), 0, 64, 0, 60'd100};
		rows[8] = '{cins(op_cmp, 16, 0, 191, 0, 100), 0, 64, 7'h08, 60'd100};
		rows[9] = '{cins(op_cmp, 16, 0, 32, 0, 0), 0, 64, 7'h10, 60'd100};
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`CMU_REG_STATUS, rv, rs);
		chk(rv, 32'h0);
		rd(8'h30, rv, rs);
		chk(rs, `CMU_RESP_SLVERR);
		wr(8'h30, 32'h1, rs);
		chk(rs, `CMU_RESP_SLVERR);
		wr(`CMU_REG_FLC, 32'd200, rs);
		wr(`CMU_REG_BASE, 32'd50, rs);
		foreach (rows[i]) begin
			load(rows[i].ins);
			wr(`CMU_REG_PARCEL, {30'h0, rows[i].par}, rs);
			wr(`CMU_REG_TBASE, {14'h0, rows[i].tbs}, rs);
			wr0 = n_wr;
			run();
			chk(st & 7'h7d, rows[i].st);
			chk(x0, rows[i].x0);
			chk(n_wr, wr0);
		end
		// Short field with jump pending and a slow memory
		xj <= 1'b1;
		slow <= 1'b1;
		load(cins(`CMU_OPC_DIR, 16, 3, 100, 7, 21));
		emove(16, 3, 100, 7, 21);
		run();
		chk(st & 7'h7d, 7'h0);
		chk_mem();
		xj <= 1'b0;
		slow <= 1'b0;
		load({`CMU_OPC_IND, 3'h0, 18'd10, 30'h0});
		emove(16, 1, 110, 2, 300);
		run();
		chk(st & 7'h7d, 7'h40);
		chk(x0, 60'h0);
		chk_mem();
		xj <= 1'b1;
		run();
		chk(st & 7'h3d, 7'h20);
		xj <= 1'b0;
		// Reset in mid-move leaves the unit idle and its setup clear
		wr(`CMU_REG_CTRL, 32'h1, rs);
		repeat (20) @(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk);
		sys_rst <= 1'b0;
		rd(`CMU_REG_STATUS, rv, rs);
		chk(rv, 32'h0);
		rd(`CMU_REG_INSTR_LO, rv, rs);
		chk(rv, 32'h0);
		test_done();
	end
endmodule

`default_nettype wire
